/* rtl/biu_consts.svh */
`ifndef BIU_CONSTS_SVH
`define BIU_CONSTS_SVH

// register indices, byte address is four times the index
`define IDX_UPPER_CFG 8'ha0
`define IDX_PERIPH_CFG 8'ha4
`define IDX_BUS_CTRL 8'hea
`define IDX_AUX_CFG 8'hf2
`define IDX_SDRAM_OPT 8'hf4
`define IDX_STATUS 8'hf6
// reset values, writable masks and fixed bits
`define RST_UPPER_CFG 16'hf03b
`define MASK_UPPER_CFG 16'h708f
`define FIXED_UPPER_CFG 16'h8030
`define RST_PERIPH_CFG 16'h0000
`define MASK_PERIPH_CFG 16'hff7f
`define RST_BUS_CTRL 16'h0000
`define MASK_BUS_CTRL 16'h8003
`define RST_SDRAM_OPT 16'h0000
`define MASK_SDRAM_OPT 16'h0001
// field positions
`define BIT_ROUTE 15
`define BIT_BOOT_W 7
`define BIT_MEM_W 1
`define BIT_IO_W 0
`define BIT_SDRAM_EN 0
`define BIT_READY_IGN 2
// address map and timing
`define LOW_HALF_TOP 20'h80000
`define UPPER_SEL_CYCLES 4
`endif

/* rtl/biu_pkg.sv */
`default_nettype none
package biu_pkg;
	// cpu bus cycle phases
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_T1 = 3'b001,
		ST_T2 = 3'b010,
		ST_T3 = 3'b011,
		ST_TW = 3'b100,
		ST_T4 = 3'b101
	} bus_state_t;
	// decoded region of a cpu cycle
	typedef enum logic [1:0] {
		TGT_OTHER = 2'b00,
		TGT_LOW = 2'b01,
		TGT_UPPER = 2'b10,
		TGT_PERIPH = 2'b11
	} target_t;
	// mac sdram access phases
	typedef enum logic [2:0] {
		M_IDLE = 3'b000,
		M_ADDR = 3'b001,
		M_DATA = 3'b010,
		M_HOLD = 3'b011,
		M_DONE = 3'b100
	} mac_state_t;
endpackage
`default_nettype wire

/* rtl/bus_interface_shadow_unit.sv */
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "biu_consts.svh"
module bus_interface_shadow_unit import biu_pkg::*; #(
	parameter int NUM_PERIPH = 10
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone register slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [1:0] wb_sel_i,
	input wire logic [15:0] wb_dat_i,
	output logic [15:0] wb_dat_o,
	output logic wb_ack_o,
	// cpu request port
	input wire logic cpu_req_i,
	input wire logic cpu_we_i,
	input wire logic cpu_io_i,
	input wire logic [19:0] cpu_addr_i,
	input wire logic cpu_high_byte_enable_n_i,
	input wire logic [15:0] cpu_wdata_i,
	output logic cpu_done_o,
	output logic [15:0] cpu_rdata_o,
	// mac sdram request port
	input wire logic mac_req_i,
	input wire logic mac_we_i,
	input wire logic [19:0] mac_addr_i,
	input wire logic [15:0] mac_wdata_i,
	output logic mac_done_o,
	output logic [15:0] mac_rdata_o,
	// reset straps
	input wire logic boot_width_strap_i,
	input wire logic slow_width_strap_i,
	// normal bus pins
	output logic [19:0] addr_pins_o,
	input wire logic [15:0] ad_i,
	output logic [15:0] ad_o,
	output logic ad_oe_o,
	output logic rd_n_o,
	output logic wr_n_o,
	output logic high_byte_enable_n_o,
	output logic [10:0] sdram_addr_pins_o,
	// slow bus pins
	input wire logic [15:0] slow_bus_pins_i,
	output logic [15:0] slow_bus_pins_o,
	output logic [1:0] slow_bus_pins_oe_o,
	output logic slow_rd_n_o,
	output logic slow_wr_n_o,
	// chip selects and ready
	output logic upper_mem_select_n_o,
	output logic low_mem_select_n_o,
	output logic [NUM_PERIPH-1:0] periph_select_n_o,
	input wire logic async_ready_in_i
);
	localparam logic [3:0] PERIPH_CNT = 4'(NUM_PERIPH); // selects in the peripheral block

	// byte-lane merge of a wishbone write
	function automatic logic [15:0] merge_lanes(input logic [15:0] old, input logic [15:0] wd,
			input logic [1:0] sel);
		return {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
	endfunction

	// wait-state code to count
	function automatic logic [3:0] wait_code(input logic [2:0] code);
		case (code)
			3'h4: return 4'h5;
			3'h5: return 4'h7;
			3'h6: return 4'h9;
			3'h7: return 4'hf;
			default: return {1'b0, code};
		endcase
	endfunction

	// start of the upper select window from the block size field
	function automatic logic [19:0] upper_start(input logic [2:0] lb);
		case (lb)
			3'h7: return 20'hf0000;
			3'h6: return 20'he0000;
			3'h4: return 20'hc0000;
			default: return 20'h80000;
		endcase
	endfunction

	// registers and configuration state
	logic [15:0] upper_cfg_ff; // upper select block size, waits, ready mode
	logic [15:0] periph_cfg_ff; // peripheral base, waits, ready mode
	logic [15:0] bus_ctrl_ff; // route select and shadow mode field
	logic [15:0] sdram_opt_ff; // sdram enable bit
	logic periph_en_ff; // peripheral selects armed by first write
	logic boot_width_flag_ff, mem_width_select_ff, io_width_select_ff;
	logic slow8_ff; // slow bus is eight bits wide
	logic captured_ff; // straps taken after reset release
	logic violation_ff; // word access refused on 8-bit slow bus
	logic boot_meta_ff, boot_sync_ff, slow_meta_ff, slow_sync_ff;
	logic [15:0] ad_meta_ff, ad_sync_ff, sad_meta_ff, sad_sync_ff;
	logic ack_ff;
	logic [15:0] dat_ff;
	logic [15:0] rd_mux;
	logic [15:0] aux_rd, status_rd;
	logic bus_req, wr_fire, viol_set;
	logic [7:0] idx;

	// cpu cycle state
	bus_state_t cpu_state_ff, nxt_cpu_state;
	mac_state_t mac_state_ff, nxt_mac_state;
	target_t c_tgt_ff, s_tgt;
	logic [19:0] c_addr_ff, s_addr;
	logic [15:0] c_wdata_ff, cpu_rdata_ff, mac_rdata_ff, mac_wdata_ff, bus_out, wr_data, in_data;
	logic [19:0] mac_addr_ff;
	logic c_we_ff, c_io_ff, c_high_byte_enable_n_ff, c_slow_ff, c_w8_ff, c_split_ff, c_half_ff, c_ign_ff;
	logic [3:0] c_waits_ff, s_waits;
	logic s_slow, s_w8, s_word, s_bad, s_ign, s_phit;
	logic cpu_start, mac_start, cpu_active, cpu_on_ad, cpu_dp, more, wait_done;
	logic cpu_done_ff, mac_done_ff, mac_we_ff, mac_active, mac_dp;

	assign bus_req = wb_cyc_i && wb_stb_i;
	assign idx = wb_adr_i[9:2];
	assign wr_fire = bus_req && wb_we_i && ack_ff; // writes land at the ack edge
	assign aux_rd = {8'h00, boot_width_flag_ff, 5'h00, mem_width_select_ff, io_width_select_ff};
	assign status_rd = {8'h00, 1'b0, cpu_state_ff, violation_ff, slow8_ff,
		mac_state_ff != M_IDLE, cpu_state_ff != ST_IDLE};

	// read mux; unmapped indices read zero
	always_comb begin
		case (idx)
			`IDX_UPPER_CFG: rd_mux = upper_cfg_ff;
			`IDX_PERIPH_CFG: rd_mux = periph_cfg_ff;
			`IDX_BUS_CTRL: rd_mux = bus_ctrl_ff;
			`IDX_AUX_CFG: rd_mux = aux_rd;
			`IDX_SDRAM_OPT: rd_mux = sdram_opt_ff;
			`IDX_STATUS: rd_mux = status_rd;
			default: rd_mux = 16'h0000;
		endcase
	end

	// wishbone ack one cycle after the strobe, data held from a register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
			dat_ff <= 16'h0000;
		end else begin
			ack_ff <= bus_req && !ack_ff;
			if (bus_req && !ack_ff) begin
				dat_ff <= rd_mux;
			end
		end
	end
	assign wb_ack_o = ack_ff;
	assign wb_dat_o = dat_ff;

	// chip-select and bus control registers; mode changes are sampled only at cycle start
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			upper_cfg_ff <= `RST_UPPER_CFG;
			periph_cfg_ff <= `RST_PERIPH_CFG;
			periph_en_ff <= 1'b0;
			bus_ctrl_ff <= `RST_BUS_CTRL;
			sdram_opt_ff <= `RST_SDRAM_OPT;
		end else if (wr_fire) begin
			case (idx)
				`IDX_UPPER_CFG: begin
					upper_cfg_ff <= (merge_lanes(upper_cfg_ff, wb_dat_i, wb_sel_i)
						& `MASK_UPPER_CFG) | `FIXED_UPPER_CFG;
				end
				`IDX_PERIPH_CFG: begin
					periph_cfg_ff <= merge_lanes(periph_cfg_ff, wb_dat_i, wb_sel_i) & `MASK_PERIPH_CFG;
					periph_en_ff <= 1'b1;
				end
				`IDX_BUS_CTRL: begin
					bus_ctrl_ff <= merge_lanes(bus_ctrl_ff, wb_dat_i, wb_sel_i) & `MASK_BUS_CTRL;
				end
				`IDX_SDRAM_OPT: begin
					sdram_opt_ff <= merge_lanes(sdram_opt_ff, wb_dat_i, wb_sel_i) & `MASK_SDRAM_OPT;
				end
				default: begin
				end
			endcase
		end
	end

	// strap synchronisers, free running
	always_ff @(posedge clk_i) begin
		boot_meta_ff <= boot_width_strap_i;
		boot_sync_ff <= boot_meta_ff;
		slow_meta_ff <= slow_width_strap_i;
		slow_sync_ff <= slow_meta_ff;
	end

	// auxiliary configuration: straps caught after release, then software
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			captured_ff <= 1'b0;
			boot_width_flag_ff <= 1'b0;
			slow8_ff <= 1'b0;
			mem_width_select_ff <= 1'b0;
			io_width_select_ff <= 1'b0;
		end else if (!captured_ff) begin
			captured_ff <= 1'b1;
			boot_width_flag_ff <= !boot_sync_ff;
			slow8_ff <= !slow_sync_ff;
		end else if (wr_fire && idx == `IDX_AUX_CFG && wb_sel_i[0]) begin
			boot_width_flag_ff <= boot_width_flag_ff && wb_dat_i[`BIT_BOOT_W];
			mem_width_select_ff <= wb_dat_i[`BIT_MEM_W];
			io_width_select_ff <= wb_dat_i[`BIT_IO_W];
		end
	end

	// sticky refusal flag, write one clears, a new event wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			violation_ff <= 1'b0;
		end else if (viol_set) begin
			violation_ff <= 1'b1;
		end else if (wr_fire && idx == `IDX_STATUS && wb_sel_i[0] && wb_dat_i[3]) begin
			violation_ff <= 1'b0;
		end
	end

	// data pin synchronisers
	always_ff @(posedge clk_i) begin
		ad_meta_ff <= ad_i;
		ad_sync_ff <= ad_meta_ff;
		sad_meta_ff <= slow_bus_pins_i;
		sad_sync_ff <= sad_meta_ff;
	end

	// decode of a new cpu request against the current modes
	always_comb begin
		s_addr = cpu_io_i ? {4'h0, cpu_addr_i[15:0]} : cpu_addr_i;
		s_phit = periph_en_ff && s_addr[19:12] == periph_cfg_ff[15:8] && s_addr[11:8] < PERIPH_CNT;
		s_tgt = s_phit ? TGT_PERIPH : TGT_OTHER;
		if (!cpu_io_i) begin
			case (bus_ctrl_ff[1:0])
				2'b00: begin
					if (s_addr < `LOW_HALF_TOP) begin
						s_tgt = TGT_LOW;
					end else if (s_addr >= upper_start(upper_cfg_ff[14:12])) begin
						s_tgt = TGT_UPPER;
					end
				end
				2'b01: begin
					s_tgt = (s_addr >= `LOW_HALF_TOP && !cpu_we_i) ? TGT_UPPER : TGT_LOW;
				end
				default: begin
					s_tgt = TGT_LOW;
				end
			endcase
		end
		s_slow = !bus_ctrl_ff[`BIT_ROUTE] && (s_tgt == TGT_PERIPH || cpu_io_i);
		case (s_tgt)
			TGT_UPPER: s_w8 = boot_width_flag_ff;
			TGT_PERIPH: s_w8 = cpu_io_i ? io_width_select_ff : mem_width_select_ff;
			TGT_OTHER: s_w8 = cpu_io_i && io_width_select_ff;
			default: s_w8 = 1'b0;
		endcase
		s_word = !s_addr[0] && !cpu_high_byte_enable_n_i;
		s_bad = s_slow && slow8_ff && s_word;
		case (s_tgt)
			TGT_UPPER: begin
				s_waits = wait_code({upper_cfg_ff[3], upper_cfg_ff[1:0]});
				s_ign = upper_cfg_ff[`BIT_READY_IGN];
			end
			TGT_PERIPH: begin
				s_waits = wait_code({periph_cfg_ff[3], periph_cfg_ff[1:0]});
				s_ign = periph_cfg_ff[`BIT_READY_IGN];
			end
			TGT_LOW: begin
				s_waits = 4'h0;
				s_ign = sdram_opt_ff[`BIT_SDRAM_EN];
			end
			default: begin
				s_waits = 4'h0;
				s_ign = 1'b0;
			end
		endcase
	end

	assign cpu_start = cpu_req_i && cpu_state_ff == ST_IDLE && !cpu_done_ff
		&& (s_slow || mac_state_ff == M_IDLE);
	assign viol_set = cpu_start && s_bad;
	assign cpu_active = cpu_state_ff != ST_IDLE;
	assign cpu_on_ad = cpu_active && !c_slow_ff;
	assign cpu_dp = cpu_state_ff == ST_T2 || cpu_state_ff == ST_T3 || cpu_state_ff == ST_TW;
	assign more = c_split_ff && !c_half_ff;

	// cpu cycle sequencer
	always_comb begin
		case (cpu_state_ff)
			ST_IDLE: nxt_cpu_state = cpu_start ? ST_T1 : ST_IDLE;
			ST_T1: nxt_cpu_state = ST_T2;
			ST_T2: nxt_cpu_state = ST_T3;
			ST_T3, ST_TW: nxt_cpu_state = wait_done ? ST_T4 : ST_TW;
			ST_T4: nxt_cpu_state = more ? ST_T1 : ST_IDLE;
			default: nxt_cpu_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cpu_state_ff <= ST_IDLE;
		end else begin
			cpu_state_ff <= nxt_cpu_state;
		end
	end

	// cycle attributes latched at request start; the second half of a split word sets address bit 0
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			c_addr_ff <= 20'h00000;
			c_wdata_ff <= 16'h0000;
			c_tgt_ff <= TGT_OTHER;
			{c_we_ff, c_io_ff, c_slow_ff, c_w8_ff, c_split_ff, c_half_ff, c_ign_ff} <= 7'h00;
			c_high_byte_enable_n_ff <= 1'b1;
			c_waits_ff <= 4'h0;
		end else if (cpu_start) begin
			c_addr_ff <= s_addr;
			c_wdata_ff <= cpu_wdata_i;
			c_tgt_ff <= s_tgt;
			c_we_ff <= cpu_we_i;
			c_io_ff <= cpu_io_i;
			c_slow_ff <= s_slow;
			c_w8_ff <= s_w8 || (s_slow && slow8_ff);
			c_split_ff <= (s_w8 || (s_slow && slow8_ff)) && s_word && !s_bad;
			c_half_ff <= 1'b0;
			c_high_byte_enable_n_ff <= cpu_high_byte_enable_n_i || s_bad;
			c_waits_ff <= s_waits;
			c_ign_ff <= s_ign;
		end else if (cpu_state_ff == ST_T4 && more) begin
			c_half_ff <= 1'b1;
			c_addr_ff[0] <= 1'b1;
		end
	end

	wait_ready_timer u_wait (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.load_i(cpu_state_ff == ST_T1),
		.wait_cnt_i(c_waits_ff),
		.ignore_i(c_ign_ff),
		.run_i(cpu_state_ff == ST_T3 || cpu_state_ff == ST_TW),
		.ready_pin_i(async_ready_in_i),
		.done_o(wait_done)
	);

	// lane steering: narrow cycles always use the low lane
	assign wr_data = c_w8_ff ? {8'h00, c_addr_ff[0] ? c_wdata_ff[15:8] : c_wdata_ff[7:0]}
		: c_wdata_ff;
	assign bus_out = (cpu_state_ff == ST_T1) ? c_addr_ff[15:0] : wr_data;
	assign in_data = c_slow_ff ? sad_sync_ff : ad_sync_ff;

	// read data and completion pulse
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cpu_rdata_ff <= 16'h0000;
			cpu_done_ff <= 1'b0;
		end else begin
			cpu_done_ff <= cpu_state_ff == ST_T4 && !more;
			if (cpu_state_ff == ST_T4 && !c_we_ff) begin
				if (!c_w8_ff) begin
					cpu_rdata_ff <= in_data;
				end else if (c_addr_ff[0]) begin
					cpu_rdata_ff[15:8] <= in_data[7:0];
				end else begin
					cpu_rdata_ff[7:0] <= in_data[7:0];
				end
			end
		end
	end
	assign cpu_done_o = cpu_done_ff;
	assign cpu_rdata_o = cpu_rdata_ff;

	// mac sdram engine, runs beside slow-bus cpu cycles
	assign mac_start = mac_req_i && mac_state_ff == M_IDLE && !mac_done_ff && !cpu_on_ad
		&& !(cpu_start && !s_slow);
	assign mac_active = mac_state_ff != M_IDLE;
	assign mac_dp = mac_state_ff == M_DATA || mac_state_ff == M_HOLD;

	always_comb begin
		case (mac_state_ff)
			M_IDLE: nxt_mac_state = mac_start ? M_ADDR : M_IDLE;
			M_ADDR: nxt_mac_state = M_DATA;
			M_DATA: nxt_mac_state = M_HOLD;
			M_HOLD: nxt_mac_state = M_DONE;
			default: nxt_mac_state = M_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mac_state_ff <= M_IDLE;
			mac_addr_ff <= 20'h00000;
			mac_wdata_ff <= 16'h0000;
			mac_we_ff <= 1'b0;
			mac_rdata_ff <= 16'h0000;
			mac_done_ff <= 1'b0;
		end else begin
			mac_state_ff <= nxt_mac_state;
			mac_done_ff <= mac_state_ff == M_DONE;
			if (mac_start) begin
				mac_addr_ff <= mac_addr_i;
				mac_wdata_ff <= mac_wdata_i;
				mac_we_ff <= mac_we_i;
			end
			if (mac_state_ff == M_DONE && !mac_we_ff) begin
				mac_rdata_ff <= ad_sync_ff;
			end
		end
	end
	assign mac_done_o = mac_done_ff;
	assign mac_rdata_o = mac_rdata_ff;

	// normal and sdram pins
	always_comb begin
		addr_pins_o = cpu_on_ad ? c_addr_ff : 20'h00000;
		ad_o = cpu_on_ad ? bus_out : (mac_active ? mac_wdata_ff : 16'h0000);
		ad_oe_o = cpu_on_ad ? (cpu_state_ff == ST_T1 || (c_we_ff && cpu_dp)) : (mac_dp && mac_we_ff);
		rd_n_o = !((cpu_on_ad && cpu_dp && !c_we_ff) || (mac_dp && !mac_we_ff));
		wr_n_o = !((cpu_on_ad && cpu_dp && c_we_ff) || (mac_dp && mac_we_ff));
		high_byte_enable_n_o = !cpu_on_ad || c_w8_ff || c_high_byte_enable_n_ff;
		sdram_addr_pins_o = mac_active ? mac_addr_ff[11:1]
			: ((cpu_on_ad && c_tgt_ff == TGT_LOW) ? c_addr_ff[11:1] : 11'h000);
	end

	// slow bus pins, upper byte lane idle when eight bits wide
	always_comb begin
		slow_bus_pins_o = (cpu_active && c_slow_ff) ? bus_out : 16'h0000;
		slow_bus_pins_oe_o[0] = cpu_active && c_slow_ff && (cpu_state_ff == ST_T1 || (c_we_ff && cpu_dp));
		slow_bus_pins_oe_o[1] = slow_bus_pins_oe_o[0] && !slow8_ff;
		slow_rd_n_o = !(cpu_active && c_slow_ff && cpu_dp && !c_we_ff);
		slow_wr_n_o = !(cpu_active && c_slow_ff && cpu_dp && c_we_ff);
	end

	// chip selects; upper select is low from the first address phase
	always_comb begin
		upper_mem_select_n_o = !(cpu_active && c_tgt_ff == TGT_UPPER);
		low_mem_select_n_o = !(mac_active || (cpu_active && c_tgt_ff == TGT_LOW));
		for (int i = 0; i < NUM_PERIPH; i++) begin
			periph_select_n_o[i] = !(cpu_active && c_tgt_ff == TGT_PERIPH
				&& c_addr_ff[11:8] == 4'(i));
		end
	end

	// checks on the block's own behaviour
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_io_addr_low: assert property (cpu_active && c_io_ff |-> addr_pins_o[19:16] == 4'h0)
		else $error("io cycle drove high address bits");
	a_slow_route: assert property (cpu_start && s_tgt == TGT_PERIPH |-> s_slow == !bus_ctrl_ff[15])
		else $error("peripheral cycle took the wrong pins");
	a_upper_fast: assert property (cpu_start && s_tgt == TGT_UPPER |-> ##[1:4] !upper_mem_select_n_o)
		else $error("upper select late");
	a_boot_sticky: assert property (captured_ff && !boot_width_flag_ff |=> !boot_width_flag_ff)
		else $error("boot width flag went back to eight bits");
	a_sdram_nowait: assert property (cpu_state_ff == ST_T3 && c_tgt_ff == TGT_LOW && c_ign_ff
		|=> cpu_state_ff == ST_T4)
		else $error("sdram cycle was stretched");
	a_ready_stretch: assert property ((cpu_state_ff == ST_T3 || cpu_state_ff == ST_TW) && !wait_done
		|=> cpu_state_ff == ST_TW)
		else $error("data phase ended while not ready");
	a_shadow_low: assert property (cpu_start && !cpu_io_i && bus_ctrl_ff[1]
		|=> c_tgt_ff == TGT_LOW && upper_mem_select_n_o [*3])
		else $error("shadow fetch not on the low select");
	a_odd_lane: assert property (cpu_on_ad && cpu_dp && c_we_ff && !c_w8_ff
		|-> ad_o[15:8] == c_wdata_ff[15:8])
		else $error("odd byte not on the high lane");
	a_cycle_stable: assert property (cpu_active && cpu_state_ff != ST_T4
		|=> $stable(c_tgt_ff) && $stable(c_slow_ff))
		else $error("cycle routing changed mid cycle");
	a_slow_narrow: assert property (slow8_ff && cpu_active && c_slow_ff |-> !slow_bus_pins_oe_o[1])
		else $error("upper slow lane driven in 8-bit mode");

	c_upper_cycle: cover property (cpu_state_ff == ST_T1 && c_tgt_ff == TGT_UPPER ##1 cpu_state_ff == ST_T2);
	c_mac_overlap: cover property (mac_active && cpu_active && c_slow_ff);
	c_split_word: cover property (cpu_state_ff == ST_T4 && more);
	c_wait_states: cover property (cpu_state_ff == ST_TW ##1 cpu_state_ff == ST_TW);
endmodule // bus_interface_shadow_unit
`default_nettype wire

/* rtl/wait_ready_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module wait_ready_timer (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// control from the cycle sequencer
	input wire logic load_i,
	input wire logic [3:0] wait_cnt_i,
	input wire logic ignore_i,
	input wire logic run_i,
	// asynchronous ready pin
	input wire logic ready_pin_i,
	// data phase may end
	output logic done_o
);
	logic rdy_meta_ff; // first synchroniser stage
	logic rdy_sync_ff; // second stage, the only one read
	logic [3:0] cnt_ff; // programmed waits still to run
	logic ign_ff; // ready ignored for this cycle

	// two-flop synchroniser on the ready pin
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdy_meta_ff <= 1'b1;
			rdy_sync_ff <= 1'b1;
		end else begin
			rdy_meta_ff <= ready_pin_i;
			rdy_sync_ff <= rdy_meta_ff;
		end
	end

	// wait-state down counter, loaded in the address phase
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_ff <= 4'h0;
			ign_ff <= 1'b0;
		end else if (load_i) begin
			cnt_ff <= wait_cnt_i;
			ign_ff <= ignore_i;
		end else if (run_i && cnt_ff != 4'h0) begin
			cnt_ff <= cnt_ff - 4'h1;
		end
	end

	// done when waits ran out and ready is high or ignored
	assign done_o = (cnt_ff == 4'h0) && (ign_ff || rdy_sync_ff);
endmodule // wait_ready_timer
`default_nettype wire

/* tb/ext_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// far-side flash, sdram and i/o device on the normal pins
module ext_mem_model (
	// clock
	input wire logic clk_i,
	// strobes, selects and pins from the unit
	input wire logic rd_n_i,
	input wire logic wr_n_i,
	input wire logic upper_n_i,
	input wire logic low_n_i,
	input wire logic [19:0] addr_i,
	input wire logic [15:0] ad_i,
	input wire logic [3:0] stall_i,
	// pins driven back
	output logic [15:0] ad_o,
	output logic ready_o,
	// what the device saw in the last data phase
	output logic [19:0] seen_a_o,
	output logic [15:0] seen_d_o,
	output logic [1:0] seen_s_o
);
	logic [15:0] junk_ff = 16'h1234; // released bus, changes every cycle
	logic [3:0] cnt_ff = 4'h0; // cycles since select fell
	logic sel; // any memory select active
	assign sel = !upper_n_i || !low_n_i;
	// read data from the address, else a changing pattern
	assign ad_o = !rd_n_i ? addr_i[15:0] ^ 16'h5a5a : junk_ff;
	// ready low from the address phase on, so it is seen before t3
	assign ready_o = !(sel && cnt_ff < stall_i);
	// capture each data phase and count select time
	always_ff @(posedge clk_i) begin
		junk_ff <= ~junk_ff ^ 16'h0101;
		cnt_ff <= sel ? cnt_ff + 4'h1 : 4'h0;
		if (!rd_n_i || !wr_n_i) begin
			seen_a_o <= addr_i;
			seen_s_o <= {!upper_n_i, !low_n_i};
			seen_d_o <= !rd_n_i ? ad_o : ad_i;
		end
	end
endmodule // ext_mem_model
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	typedef struct {logic [19:0] a; logic [15:0] d; logic [1:0] s; logic w; int t; int lo; int hi;} note_t;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
	logic [9:0] wb_adr_i = 10'h000;
	logic [1:0] wb_sel_i = 2'h3, slow_bus_pins_oe_o, seen_s;
	logic [15:0] wb_dat_i = 16'h0000, wb_dat_o, cpu_wdata_i = 16'h0000, cpu_rdata_o;
	logic [15:0] mac_wdata_i = 16'h0000, mac_rdata_o, ad_i, ad_o, slow_bus_pins_o, seen_d;
	logic cpu_req_i = 1'b0, cpu_we_i = 1'b0, cpu_io_i = 1'b0, cpu_high_byte_enable_n_i = 1'b0;
	logic [19:0] cpu_addr_i = 20'h00000, mac_addr_i = 20'h00000, addr_pins_o, seen_a;
	logic mac_req_i = 1'b0, mac_we_i = 1'b0, boot_width_strap_i = 1'b0, slow_width_strap_i = 1'b1;
	logic cpu_done_o, mac_done_o, ad_oe_o, rd_n_o, wr_n_o, high_byte_enable_n_o, slow_rd_n_o;
	logic slow_wr_n_o, upper_mem_select_n_o, low_mem_select_n_o, async_ready_in_i;
	logic [10:0] sdram_addr_pins_o;
	logic [9:0] periph_select_n_o;
	logic [3:0] stall = 4'h0; // ready-low cycles the far side asks for
	int seed = 32'ha774167e, cyc_cnt = 0, err_total = 0, compares = 0;
	logic [19:0] wq[$]; // expected register reads
	note_t cq[$]; // expected cpu cycles
	int mq[$]; // start times of mac sdram reads
	// unit under test, normal pins served by the model
	bus_interface_shadow_unit i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cpu_req_i, .cpu_we_i, .cpu_io_i, .cpu_addr_i,
		.cpu_high_byte_enable_n_i, .cpu_wdata_i, .cpu_done_o, .cpu_rdata_o, .mac_req_i, .mac_we_i,
		.mac_addr_i, .mac_wdata_i, .mac_done_o, .mac_rdata_o, .boot_width_strap_i,
		.slow_width_strap_i, .addr_pins_o, .ad_i, .ad_o, .ad_oe_o, .rd_n_o, .wr_n_o,
		.high_byte_enable_n_o, .sdram_addr_pins_o, .slow_bus_pins_i(~slow_bus_pins_o),
		.slow_bus_pins_o, .slow_bus_pins_oe_o, .slow_rd_n_o, .slow_wr_n_o, .upper_mem_select_n_o,
		.low_mem_select_n_o, .periph_select_n_o, .async_ready_in_i);
	ext_mem_model i_mem (.clk_i, .rd_n_i(rd_n_o), .wr_n_i(wr_n_o), .upper_n_i(upper_mem_select_n_o),
		.low_n_i(low_mem_select_n_o), .addr_i(addr_pins_o), .ad_i(ad_o), .stall_i(stall),
		.ad_o(ad_i), .ready_o(async_ready_in_i), .seen_a_o(seen_a), .seen_d_o(seen_d),
		.seen_s_o(seen_s));
	// 200 mhz clock and edge counter
	initial begin
		forever #2.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) cyc_cnt <= cyc_cnt + 1;
	// value and latency comparisons
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_lat(input int l, input int lo, input int hi);
		compares++;
		if (l < lo || l > hi) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, l, lo);
		end
	endtask
	task automatic end_sim();
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// wishbone classic single cycle, bounded wait for ack
	task automatic wb(input logic w, input logic [7:0] idx, input logic [15:0] d);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= {idx, 2'b00};
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
		if (n >= 50) begin
			err_total++;
			end_sim();
		end
	endtask
	task automatic wbr(input logic [7:0] idx, input logic [15:0] e);
		wq.push_back({4'h0, e});
		wb(1'b0, idx, 16'h0000);
	endtask
	// one cpu cycle in region nib, expected select and latency window
	task automatic cpu(input logic w, io, input logic [3:0] nib, input logic [1:0] s,
		input int lo, hi, input logic [3:0] st);
		note_t n;
		int k;
		n.a = {io ? 4'h0 : nib, 16'($random(seed)) & 16'hfffe};
		n.d = w ? 16'($random(seed)) : n.a[15:0] ^ 16'h5a5a;
		n = '{n.a, n.d, s, w, cyc_cnt, lo, hi};
		cq.push_back(n);
		cpu_req_i <= 1'b1;
		cpu_we_i <= w;
		cpu_io_i <= io;
		cpu_addr_i <= {nib, n.a[15:0]};
		cpu_wdata_i <= n.d;
		stall <= st;
		{mac_addr_i, mac_wdata_i} <= {$random(seed), 4'h3};
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (cpu_done_o !== 1'b1 && k < 200);
		cpu_req_i <= 1'b0;
		@(posedge clk_i);
		if (k >= 200) begin
			err_total++;
			end_sim();
		end
	endtask
	// one mac sdram read while the cpu is idle, bounded wait for done
	task automatic mac(input logic [19:0] a);
		int k;
		k = 0;
		mq.push_back(cyc_cnt);
		mac_req_i <= 1'b1;
		mac_we_i <= 1'b0;
		mac_addr_i <= a;
		do begin
			@(posedge clk_i);
			k++;
		end while (mac_done_o !== 1'b1 && k < 50);
		mac_req_i <= 1'b0;
		@(posedge clk_i);
		if (k >= 50) begin
			err_total++;
			end_sim();
		end
	endtask
	// result watcher: oldest note against each answer
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
			chk(wq.pop_front(), {4'h0, wb_dat_o});
		end
		if (cpu_done_o === 1'b1) begin
			chk_lat(cyc_cnt - cq[0].t, cq[0].lo, cq[0].hi);
			chk(seen_a, cq[0].a);
			chk({18'h0, seen_s}, {18'h0, cq[0].s});
			chk({4'h0, seen_d}, {4'h0, cq[0].d});
			if (!cq[0].w) chk({4'h0, cpu_rdata_o}, {4'h0, cq[0].d});
			void'(cq.pop_front());
		end
		if (mac_done_o === 1'b1) begin
			chk_lat(cyc_cnt - mq[0], 6, 6);
			chk({4'h0, mac_rdata_o}, 20'h05a5a);
			void'(mq.pop_front());
		end
	end
	// main sequence
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		wbr(8'ha0, 16'hf03b);
		wbr(8'hea, 16'h0000);
		wbr(8'hf2, 16'h0080);
		wb(1'b1, 8'hff, 16'hffff);
		wbr(8'hff, 16'h0000);
		wb(1'b1, 8'hf2, 16'h0000);
		wbr(8'hf2, 16'h0000);
		wb(1'b1, 8'hf2, 16'h0080);
		wbr(8'hf2, 16'h0000);
		cpu(1'b0, 1'b0, 4'hf, 2'b10, 21, 21, 4'h0);
		wb(1'b1, 8'ha0, 16'h0000);
		wbr(8'ha0, 16'h8030);
		cpu(1'b0, 1'b0, 4'h9, 2'b10, 9, 13, 4'h4);
		wb(1'b1, 8'hf4, 16'h0001);
		for (int m = 0; m < 4; m++) begin
			wb(1'b1, 8'hea, {1'b1, 13'h0, m[1:0]});
			cpu(1'b0, 1'b0, 4'h9, m < 2 ? 2'b10 : 2'b01, 6, 6, 4'h0);
			cpu(1'b1, 1'b0, 4'h9, m == 0 ? 2'b10 : 2'b01, 6, 6, 4'h0);
			cpu(1'b1, 1'b0, 4'h1, 2'b01, 6, 6, 4'h3);
		end
		cpu(1'b0, 1'b1, 4'hf, 2'b00, 6, 6, 4'h0);
		wbr(8'hea, 16'h8003);
		wb(1'b1, 8'hf2, 16'h0083);
		wbr(8'hf2, 16'h0003);
		mac(20'($random(seed)));
		end_sim();
	end
endmodule // tb_top
`default_nettype wire
